// ===== pkg/rsc_pkg.sv
package rsc_pkg;
    // register map, byte addresses on the word-wide slave
    localparam logic [3:0]  RSC_CFG_OFS       = 4'h0;
    localparam logic [3:0]  RSC_STAT_OFS      = 4'h4;
    // configuration field positions
    localparam int          RSC_RSV_HI_MSB    = 15;
    localparam int          RSC_RSV_HI_LSB    = 8;
    localparam int          RSC_RSV7_BIT      = 7;
    localparam int          RSC_CLK_SE_BIT    = 6;
    localparam int          RSC_SLEEP_BIT     = 5;
    localparam int          RSC_PAR_MSB       = 4;
    localparam int          RSC_PAR_LSB       = 2;
    localparam int          RSC_INTV_MSB      = 1;
    // status field positions
    localparam int          RSC_ST_SLEEP_BIT  = 0;
    localparam int          RSC_ST_BUSY_BIT   = 1;
    localparam int          RSC_ST_PEND_BIT   = 2;
    localparam int          RSC_ST_XLAT_BIT   = 3;
    localparam int          RSC_ST_ROW_LSB    = 16;
    // reset values
    localparam logic [7:0]  RSC_RSV_HI_RST    = 8'hff;
    localparam logic        RSC_RSV7_VAL      = 1'b1;
    localparam logic        RSC_CLK_SE_RST    = 1'b1;
    localparam logic        RSC_SLEEP_RST     = 1'b0;
    localparam logic [2:0]  RSC_PAR_RST       = 3'h0;
    // read-only refresh interval class
    localparam logic [1:0]  RSC_INTV_4US      = 2'h1;
    localparam logic [1:0]  RSC_INTV_1US      = 2'h2;
    // partial refresh region codes
    localparam logic [2:0]  RSC_PAR_FULL      = 3'h0;
    localparam logic [2:0]  RSC_PAR_BOT_HALF  = 3'h1;
    localparam logic [2:0]  RSC_PAR_BOT_QTR   = 3'h2;
    localparam logic [2:0]  RSC_PAR_BOT_8TH   = 3'h3;
    localparam logic [2:0]  RSC_PAR_NONE      = 3'h4;
    localparam logic [2:0]  RSC_PAR_TOP_HALF  = 3'h5;
    localparam logic [2:0]  RSC_PAR_TOP_QTR   = 3'h6;
    localparam logic [2:0]  RSC_PAR_TOP_8TH   = 3'h7;
    // timing
    localparam int          RSC_ROW_W         = 13;
    localparam int          RSC_ROWS          = 8192;
    localparam int          RSC_CLK_NS        = 100;
    localparam int          RSC_ARRAY_MS_COOL = 64;
    localparam int          RSC_ARRAY_MS_HOT  = 16;
    // per-row spacing rounds down: a longest time
    localparam int          RSC_ROW_CYC_COOL  = (RSC_ARRAY_MS_COOL * 1000000)
                                                / (RSC_ROWS * RSC_CLK_NS);
    localparam int          RSC_ROW_CYC_HOT   = (RSC_ARRAY_MS_HOT * 1000000)
                                                / (RSC_ROWS * RSC_CLK_NS);
    localparam logic [7:0]  RSC_ROW_TMR_COOL  = 8'(RSC_ROW_CYC_COOL - 1);
    localparam logic [7:0]  RSC_ROW_TMR_HOT   = 8'(RSC_ROW_CYC_HOT - 1);
    localparam logic [1:0]  RSC_REFRESH_CYC   = 2'h2;
    localparam logic [1:0]  RSC_PEND_MAX      = 2'h3;
    localparam logic [2:0]  RSC_CMD_EDGES     = 3'h6;
endpackage : rsc_pkg

// ===== src/rsc_sync.sv
`timescale 1ns/1ns
module rsc_sync
    import rsc_pkg::*;
#(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta   <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : rsc_sync

// ===== src/rsc_refresh_sched.sv
`timescale 1ns/1ns
module rsc_refresh_sched
    import rsc_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 hot_i,
    input  wire logic [2:0]           region_i,
    input  wire logic                 host_idle_i,
    output logic                      busy_o,
    output logic                      pending_o,
    output logic                      row_stb_o,
    output logic      [RSC_ROW_W-1:0] row_o
);
    logic [7:0]           tmr;
    logic [1:0]           pend;
    logic [1:0]           busy_cnt;
    logic [RSC_ROW_W-1:0] ptr;

    function automatic logic [RSC_ROW_W-1:0] region_mask(input logic [2:0] c);
        unique case (c[1:0])
            2'h0:    region_mask = 13'h1fff;
            2'h1:    region_mask = 13'h0fff;
            2'h2:    region_mask = 13'h07ff;
            default: region_mask = 13'h03ff;
        endcase
    endfunction : region_mask

    wire                 none      = (region_i == RSC_PAR_NONE);
    wire                 top       = region_i[2] && !none;
    wire [RSC_ROW_W-1:0] mask      = region_mask(region_i);
    wire [RSC_ROW_W-1:0] base      = top ? ~mask : 13'h0000;
    wire                 tick      = (tmr == 8'h00);
    // refresh only in gaps between host accesses, queued work waits
    wire                 start     = host_idle_i && !busy_o && (pend != 2'h0);
    wire                 pend_up   = tick && !none && (pend != RSC_PEND_MAX);
    wire [7:0]           tmr_load  = hot_i ? RSC_ROW_TMR_HOT : RSC_ROW_TMR_COOL;

    // one row per spacing, queue of three lets a long access be caught up
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tmr <= 8'h00;
            pend <= 2'h0;
        end else begin
            tmr <= tick ? tmr_load : tmr - 8'h01;
            if (none)
                pend <= 2'h0;
            else if (pend_up && !start)
                pend <= pend + 2'h1;
            else if (start && !pend_up)
                pend <= pend - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            busy_cnt <= 2'h0;
            ptr <= 13'h0000;
            row_o <= 13'h0000;
            row_stb_o <= 1'b0;
        end else begin
            row_stb_o <= start;
            if (start) begin
                busy_cnt <= RSC_REFRESH_CYC;
                ptr <= (ptr + 13'h0001) & mask;
                row_o <= base | (ptr & mask);
            end else if (busy_cnt != 2'h0) begin
                busy_cnt <= busy_cnt - 2'h1;
            end
        end
    end

    assign busy_o    = (busy_cnt != 2'h0);
    assign pending_o = (pend != 2'h0);
endmodule : rsc_refresh_sched

// ===== src/rsc_refresh_sleep_config.sv
`timescale 1ns/1ns
module rsc_refresh_sleep_config
    import rsc_pkg::*;
#(
    parameter logic HOT_GRADE = 1'b0
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // memory bus pins
    input  wire logic                 chip_select_b_i,
    input  wire logic                 bus_tick_i,
    input  wire logic                 inverted_bus_tick_i,
    input  wire logic                 read_write_strobe_i,
    output logic                      read_write_strobe_o,
    output logic                      read_write_strobe_oe_o,
    // array side
    output logic                      retention_sleep_state_o,
    output logic                      refresh_row_stb_o,
    output logic      [RSC_ROW_W-1:0] refresh_row_o,
    output logic                      inverted_tick_en_o
);
    typedef enum logic [1:0] {RSC_IDLE, RSC_CMD_ADDR, RSC_XFER} rsc_link_t;

    logic [2:0]           pins_s;
    logic                 tick_q;
    logic                 cs_b_q;
    logic [7:0]           rsv_hi;
    logic                 clk_se;
    logic                 sleep;
    logic [2:0]           region;
    logic [2:0]           edge_cnt;
    logic                 xlat;
    rsc_link_t            link_st;
    rsc_link_t            next_link_st;
    logic                 rf_busy;
    logic                 rf_pend;
    logic                 rf_stb;
    logic [RSC_ROW_W-1:0] rf_row;

    rsc_sync #(
        .W       (3),
        // idle pin levels, so no false tick edge follows reset
        .RST_VAL (3'h6)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .async_i ({chip_select_b_i, inverted_bus_tick_i, bus_tick_i}),
        .sync_o  (pins_s)
    );

    // strobe input is only meaningful for masked writes, not handled here
    wire        unused_strobe_in = read_write_strobe_i;

    wire        cs_b_s      = pins_s[2];
    // single-ended ignores the complement entirely
    wire        tick_lvl    = clk_se ? pins_s[0] : (pins_s[0] & ~pins_s[1]);
    wire        tick_edge   = tick_lvl ^ tick_q;
    wire        cs_fall     = cs_b_q && !cs_b_s;
    wire        host_idle   = cs_b_s && cs_b_q;
    wire [1:0]  intv        = HOT_GRADE ? RSC_INTV_1US : RSC_INTV_4US;

    // bus decode
    wire        req         = avs_read_i || avs_write_i;
    wire        take        = req && avs_waitrequest_o;
    wire        sel_cfg     = (avs_address_i == RSC_CFG_OFS);
    wire        sel_stat    = (avs_address_i == RSC_STAT_OFS);
    wire        wr_cfg      = avs_write_i && !avs_waitrequest_o && sel_cfg;
    wire        wr_lo       = wr_cfg && avs_byteenable_i[0];
    wire        wr_hi       = wr_cfg && avs_byteenable_i[1];
    wire        sleep_set   = wr_lo && avs_writedata_i[RSC_SLEEP_BIT];
    wire        sleep_clr   = wr_lo && !avs_writedata_i[RSC_SLEEP_BIT];

    wire [15:0] cfg_word    = {rsv_hi, RSC_RSV7_VAL, clk_se, sleep, region, intv};
    wire [31:0] stat_word   = {3'h0, rf_row, 12'h000, xlat, rf_pend, rf_busy, sleep};
    wire [31:0] rd_mux      = sel_cfg  ? {16'h0000, cfg_word} :
                              sel_stat ? stat_word : 32'h0000_0000;

    // one wait cycle: request taken, then answered at the next edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= !take;
            if (take && avs_read_i)
                avs_readdata_o <= rd_mux;
        end
    end

    // configuration fields; bits 1:0 and 7 have no storage
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rsv_hi <= RSC_RSV_HI_RST;
            clk_se <= RSC_CLK_SE_RST;
            region <= RSC_PAR_RST;
        end else begin
            if (wr_hi)
                rsv_hi <= avs_writedata_i[RSC_RSV_HI_MSB:RSC_RSV_HI_LSB];
            if (wr_lo) begin
                clk_se <= avs_writedata_i[RSC_CLK_SE_BIT];
                region <= avs_writedata_i[RSC_PAR_MSB:RSC_PAR_LSB];
            end
        end
    end

    // reset leaves sleep; a write of one in the select-low cycle wins
    always_ff @(posedge clk_i) begin
        if (!rst_b_i)
            sleep <= RSC_SLEEP_RST;
        else if (sleep_set)
            sleep <= 1'b1;
        else if (sleep_clr || (sleep && cs_fall))
            sleep <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_q <= 1'b0;
            cs_b_q <= 1'b1;
        end else begin
            tick_q <= tick_lvl;
            cs_b_q <= cs_b_s;
        end
    end

    // refresh runs in sleep as well, so the array holds its data
    rsc_refresh_sched u_sched (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .hot_i       (HOT_GRADE),
        .region_i    (region),
        .host_idle_i (host_idle),
        .busy_o      (rf_busy),
        .pending_o   (rf_pend),
        .row_stb_o   (rf_stb),
        .row_o       (rf_row)
    );

    // link phases
    always_comb begin
        next_link_st = link_st;
        unique case (link_st)
            RSC_IDLE: if (cs_fall && !sleep) next_link_st = RSC_CMD_ADDR;
            RSC_CMD_ADDR: begin
                if (cs_b_s)
                    next_link_st = RSC_IDLE;
                else if (tick_edge && edge_cnt == RSC_CMD_EDGES - 3'h1)
                    next_link_st = RSC_XFER;
            end
            RSC_XFER: if (cs_b_s) next_link_st = RSC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            link_st  <= RSC_IDLE;
            edge_cnt <= 3'h0;
            xlat     <= 1'b0;
        end else begin
            link_st <= next_link_st;
            if (link_st != RSC_CMD_ADDR)
                edge_cnt <= 3'h0;
            else if (tick_edge)
                edge_cnt <= edge_cnt + 3'h1;
            if (cs_fall)
                xlat <= rf_busy || rf_pend;
        end
    end

    // strobe driven only through command-address
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            read_write_strobe_o    <= 1'b0;
            read_write_strobe_oe_o <= 1'b0;
        end else begin
            read_write_strobe_oe_o <= (next_link_st == RSC_CMD_ADDR);
            read_write_strobe_o    <= (next_link_st == RSC_CMD_ADDR) &&
                                      (cs_fall ? (rf_busy || rf_pend) : xlat);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            retention_sleep_state_o <= RSC_SLEEP_RST;
            refresh_row_stb_o       <= 1'b0;
            refresh_row_o           <= 13'h0000;
            inverted_tick_en_o      <= 1'b0;
        end else begin
            retention_sleep_state_o <= sleep;
            refresh_row_stb_o       <= rf_stb;
            refresh_row_o           <= rf_row;
            inverted_tick_en_o      <= !clk_se;
        end
    end
endmodule : rsc_refresh_sleep_config

// ===== sim/rsc_refresh_sleep_config_assertions.sv
`timescale 1ns/1ns
module rsc_refresh_sleep_config_assertions
    import rsc_pkg::*;
#(
    parameter logic HOT_GRADE = 1'b0
) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        chip_select_b_i,
    input wire logic        read_write_strobe_o,
    input wire logic        read_write_strobe_oe_o,
    input wire logic        retention_sleep_state_o,
    input wire logic        refresh_row_stb_o,
    input wire logic        inverted_tick_en_o
);
    logic [3:0] lo_cnt;
    logic [3:0] hi_cnt;
    wire logic  cfg_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                         && (avs_address_i == RSC_CFG_OFS);
    wire logic  cfg_rd = avs_read_i && avs_waitrequest_o && (avs_address_i == RSC_CFG_OFS);
    // saturating run lengths of the raw select pin, sync delay stays inside
    always_ff @(posedge clk_i) begin
        lo_cnt <= (!rst_b_i || chip_select_b_i) ? 4'h0 : lo_cnt + 4'(lo_cnt != 4'hf);
        hi_cnt <= (!rst_b_i || !chip_select_b_i) ? 4'h0 : hi_cnt + 4'(hi_cnt != 4'hf);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd_taken;
        cfg_rd;
    endsequence
    sequence s_wake;
        retention_sleep_state_o && $fell(chip_select_b_i) && !avs_write_i;
    endsequence
    a_rsv7_reads_one: assert property (s_rd_taken |=> avs_readdata_o[7])
        else $error("reserved bit 7 read as zero");
    a_intv_class: assert property (s_rd_taken |=> avs_readdata_o[1:0] ==
        (HOT_GRADE ? RSC_INTV_1US : RSC_INTV_4US)) else $error("interval class wrong");
    a_sleep_entry: assert property (cfg_wr && avs_writedata_i[5]
        |-> ##[1:2] retention_sleep_state_o) else $error("sleep not entered");
    a_sleep_wake: assert property (s_wake |-> ##[1:8] !retention_sleep_state_o)
        else $error("select low did not wake");
    a_reset_ends_sleep: assert property ($rose(rst_b_i) |-> !retention_sleep_state_o)
        else $error("sleep survived reset");
    a_diff_enable: assert property (cfg_wr && !avs_writedata_i[6]
        |-> ##[1:2] inverted_tick_en_o) else $error("complement input not enabled");
    a_single_ignore: assert property (cfg_wr && avs_writedata_i[6]
        |-> ##[1:2] !inverted_tick_en_o) else $error("complement input still enabled");
    a_no_refresh_busy: assert property (lo_cnt >= 4'h8 |-> !refresh_row_stb_o)
        else $error("row refreshed during access");
    a_strobe_framed: assert property (hi_cnt >= 4'h5 |-> !read_write_strobe_oe_o)
        else $error("strobe driven outside access");
    a_strobe_needs_oe: assert property (read_write_strobe_o |-> read_write_strobe_oe_o)
        else $error("strobe high while not driven");
endmodule : rsc_refresh_sleep_config_assertions

// ===== sim/rsc_host_model.sv
`timescale 1ns/1ns
module rsc_host_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [2:0] frames_i,
    input  wire logic [3:0] edges_i,
    output logic            cs_b_o,
    output logic            tick_o,
    output logic            tick_n_o,
    output logic            done_o
);
    initial begin
        cs_b_o = 1'b1;
        tick_o = 1'b0;
        tick_n_o = 1'b1;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            done_o <= 1'b0;
            if (go_i) begin
                for (int f = 0; f < frames_i; f++) begin
                    cs_b_o <= 1'b0;
                    // odd offset keeps the link clock off the system clock phase
                    #237;
                    for (int e = 0; e < edges_i; e++) begin
                        #400 tick_o = ~tick_o;
                        tick_n_o = ~tick_o;
                    end
                    @(posedge clk_i);
                    cs_b_o <= 1'b1;
                    @(posedge clk_i);
                end
                done_o <= 1'b1;
            end
        end
    end
endmodule : rsc_host_model

// ===== sim/rsc_refresh_sleep_config_tb.sv
`timescale 1ns/1ns
module rsc_refresh_sleep_config_tb
    import rsc_pkg::*;
;
    localparam int ROW_GAP = (64 * 1000000) / (8192 * 100);
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'h3;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        cs_b, tick, tick_n, done, strobe, strobe_oe, sleep, row_stb, tick_en;
    logic        go = 1'b0;
    logic [2:0]  frames = 3'h1;
    logic [3:0]  edges = 4'h6;
    logic [12:0] row;
    logic [31:0] q;
    int          failures = 0;
    int          total_checks = 0;
    int          rows_seen = 0;
    int          late_seen = 0;
    int          oe_seen = 0;
    int          n0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        rows_seen <= rows_seen + int'(row_stb === 1'b1);
        late_seen <= late_seen + int'(strobe_oe === 1'b1 && strobe === 1'b1);
        oe_seen <= oe_seen + int'(strobe_oe === 1'b1);
    end
    rsc_refresh_sleep_config u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .chip_select_b_i(cs_b), .bus_tick_i(tick),
        .inverted_bus_tick_i(tick_n), .read_write_strobe_i(1'b0), .read_write_strobe_o(strobe),
        .read_write_strobe_oe_o(strobe_oe), .retention_sleep_state_o(sleep),
        .refresh_row_stb_o(row_stb), .refresh_row_o(row), .inverted_tick_en_o(tick_en));
    rsc_host_model u_host (.clk_i(clk_i), .go_i(go), .frames_i(frames), .edges_i(edges),
        .cs_b_o(cs_b), .tick_o(tick), .tick_n_o(tick_n), .done_o(done));
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    task automatic do_reset;
        rst_b_i <= 1'b0;
        idle(10);
        rst_b_i <= 1'b1;
        idle(1);
    endtask : do_reset
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        idle(1);
        if (k >= 50) begin
            failures++;
            complete_run();
        end
    endtask : bus
    task automatic frame(input logic [2:0] n, input logic [3:0] e);
        int k;
        k = 0;
        frames <= n;
        edges <= e;
        go <= 1'b1;
        idle(1);
        go <= 1'b0;
        while (done !== 1'b1 && k < 600) begin
            idle(1);
            k++;
        end
        if (k >= 600) begin
            failures++;
            complete_run();
        end
    endtask : frame
    task automatic t_fields;
        bus(0, RSC_CFG_OFS, 32'h0000_0000);
        check("cfg reset", 32'h0000_ffc1, q);
        check("tick enable reset", 32'h0, {31'h0, tick_en});
        for (int c = 0; c < 8; c++) begin
            // bit 7 and the interval bits are written wrong on purpose
            bus(1, RSC_CFG_OFS, {16'h0000, 8'hff, 3'b000, 3'(c), 2'b10});
            bus(0, RSC_CFG_OFS, 32'h0000_0000);
            check("partial field", {16'h0000, 8'hff, 3'b100, 3'(c), 2'b01}, q);
            check("tick enable diff", 32'h1, {31'h0, tick_en});
        end
        // a transfer with the complement clock qualifying the tick
        n0 = oe_seen;
        frame(1, 6);
        check("strobe drive diff", 32'h1, 32'(oe_seen - n0 > 0));
        bus(1, RSC_CFG_OFS, 32'h0000_ffc2);
        bus(0, RSC_CFG_OFS, 32'h0000_0000);
        check("cfg single", 32'h0000_ffc1, q);
        check("tick enable single", 32'h0, {31'h0, tick_en});
        bus(1, 4'h8, 32'hffff_ffff);
        bus(0, 4'h8, 32'h0000_0000);
        check("unmapped read", 32'h0, q);
        bus(0, RSC_CFG_OFS, 32'h0000_0000);
        check("cfg after unmapped", 32'h0000_ffc1, q);
    endtask : t_fields
    task automatic t_sleep;
        bus(1, RSC_CFG_OFS, 32'h0000_ffe1);
        idle(2);
        check("sleep entry", 32'h1, {31'h0, sleep});
        n0 = rows_seen;
        idle(4 * ROW_GAP);
        check("rows in sleep", 32'h1, 32'(rows_seen - n0 >= 3));
        n0 = oe_seen;
        frame(1, 6);
        idle(3);
        check("no strobe on wake", 32'h0, 32'(oe_seen - n0));
        check("sleep wake", 32'h0, {31'h0, sleep});
        bus(0, RSC_CFG_OFS, 32'h0000_0000);
        check("sleep bit cleared", 32'h0000_ffc1, q);
        bus(1, RSC_CFG_OFS, 32'h0000_ffe1);
        do_reset();
        check("sleep after reset", 32'h0, {31'h0, sleep});
    endtask : t_sleep
    task automatic t_refresh;
        n0 = rows_seen;
        idle(10 * ROW_GAP);
        check("rows spread", 32'h1, 32'(rows_seen - n0 inside {[9:11]}));
        bus(1, RSC_CFG_OFS, 32'h0000_ffd1);
        idle(5);
        n0 = rows_seen;
        idle(3 * ROW_GAP);
        check("rows region none", 32'h0, 32'(rows_seen - n0));
        n0 = late_seen;
        frame(1, 6);
        check("no extra latency", 32'h0, 32'(late_seen - n0));
        bus(1, RSC_CFG_OFS, 32'h0000_ffc1);
        // refresh starved across back-to-back accesses must show on the strobe
        frame(4, 8);
        check("extra latency", 32'h1, 32'(late_seen > n0));
    endtask : t_refresh
    task automatic t_region;
        int k;
        k = 0;
        bus(1, RSC_CFG_OFS, 32'h0000_ffdd);
        // let a row started under the old region pass first
        idle(3);
        while (row_stb !== 1'b1 && k < 200) begin
            idle(1);
            k++;
        end
        if (k >= 200) begin
            failures++;
            complete_run();
        end
        check("row top eighth", 32'h7, 32'(row[12:10]));
        bus(0, RSC_STAT_OFS, 32'h0000_0000);
        check("status row", 32'h7, 32'(q[28:26]));
        check("status sleep", 32'h0, 32'(q[0]));
    endtask : t_region
    initial begin
        do_reset();
        t_fields();
        t_sleep();
        t_refresh();
        t_region();
        complete_run();
    end
endmodule : rsc_refresh_sleep_config_tb
bind rsc_refresh_sleep_config rsc_refresh_sleep_config_assertions #(.HOT_GRADE(HOT_GRADE)) u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .chip_select_b_i(chip_select_b_i),
    .read_write_strobe_o(read_write_strobe_o), .read_write_strobe_oe_o(read_write_strobe_oe_o),
    .retention_sleep_state_o(retention_sleep_state_o), .refresh_row_stb_o(refresh_row_stb_o),
    .inverted_tick_en_o(inverted_tick_en_o));
